// >>> bench/isfl_link_sva.sv
`timescale 1ns/1ns
module isfl_link_sva
	import isfl_pkg::*;
#(
	parameter int HALF_CYC = 4
)
(
	// System
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	// Link wires
	input wire logic link_clock_in,
	input wire logic serial_data_in,
	input wire logic serial_data_out,
	input wire logic clear_to_send_out
);
	import isfl_pkg::*;

	logic lc_q;
	logic rise;
	logic [7:0] hi_cnt;
	logic [3:0] rx_cnt;
	logic [3:0] tx_cnt;

	assign rise = link_clock_in & ~lc_q;

	always_ff @(posedge clk_sys_i)
	begin
		lc_q <= ~sys_rst_i & link_clock_in;
		hi_cnt <= (sys_rst_i | ~link_clock_in) ? 8'h00 : hi_cnt + 8'h01;
	end

	// Bits taken at the sampling end, per direction
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			rx_cnt <= 4'h0;
		else if (rise & ((rx_cnt != 4'h0) | ~serial_data_in))
			rx_cnt <= (rx_cnt == 4'h9) ? 4'h0 : rx_cnt + 4'h1;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			tx_cnt <= 4'h0;
		else if (rise & ((tx_cnt != 4'h0) | ~serial_data_out))
			tx_cnt <= (tx_cnt == 4'hA) ? 4'h0 : tx_cnt + 4'h1;
	end

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (sys_rst_i);

	sequence s_rx_start;
		rise && rx_cnt == 4'h0 && !serial_data_in && clear_to_send_out;
	endsequence

	sequence s_tx_start;
		$fell(serial_data_out) && tx_cnt == 4'h0;
	endsequence

	property p_clk_high;
		$fell(link_clock_in) |-> hi_cnt == 8'(HALF_CYC);
	endproperty
	a_clk_high: assert property (p_clk_high)
		else $error("link clock high phase wrong");

	property p_tx_start;
		s_tx_start |-> !serial_data_out [*5];
	endproperty
	a_tx_start: assert property (p_tx_start)
		else $error("start bit too short");

	property p_tx_not_in_rx;
		s_tx_start |-> !(rx_cnt inside {[4'h1:4'h8]});
	endproperty
	a_tx_not_in_rx: assert property (p_tx_not_in_rx)
		else $error("frame sent during reception");

	property p_tx_stop;
		rise && tx_cnt == 4'hA |-> serial_data_out;
	endproperty
	a_tx_stop: assert property (p_tx_stop)
		else $error("frame longer than ten bits");

	property p_sdo_timing;
		$changed(serial_data_out) |-> $past(rise, 2) || $past(rise, 3) || $past(rise, 4);
	endproperty
	a_sdo_timing: assert property (p_sdo_timing)
		else $error("data out moved away from link edge");

	property p_cts_drop;
		s_rx_start |-> ##[1:14] !clear_to_send_out;
	endproperty
	a_cts_drop: assert property (p_cts_drop)
		else $error("clear to send not dropped");

	property p_cts_low;
		rx_cnt inside {[4'h3:4'h9]} |-> !clear_to_send_out;
	endproperty
	a_cts_low: assert property (p_cts_low)
		else $error("clear to send high in frame");

	property p_ext_cts;
		$fell(serial_data_in) && rx_cnt == 4'h0 |-> clear_to_send_out;
	endproperty
	a_ext_cts: assert property (p_ext_cts)
		else $error("frame begun without clear to send");
endmodule

// >>> bench/tb_isolated_fast_serial_link.sv
`timescale 1ns/1ns
module tb_isolated_fast_serial_link;
	import isfl_pkg::*;
	localparam int LIM = 4000;
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [1:0] cfg = 2'b11;
	logic [7:0] bm = 8'h00;
	logic bm_wr = 1'b0;
	logic [1:0][7:0] d_txd = '0;
	logic [1:0] d_txv = 2'b00;
	logic [1:0] d_rdy = 2'b11;
	logic [7:0] e_txd = 8'h00;
	logic e_dst = 1'b0;
	logic e_txv = 1'b0;
	logic e_rdy = 1'b1;
	logic [1:0] d_trdy;
	logic [7:0] d_rxd;
	logic [1:0] d_rxv;
	logic pins;
	logic held;
	logic e_trdy;
	logic [7:0] e_rxd;
	logic e_src;
	logic e_rxv;
	int failures = 0;
	int total_checks = 0;
	int seed = 32'h76cc852e;
	logic [7:0] exp_e[2][$];
	logic [9:0] exp_d[$];

	always #10 clk_sys_i = ~clk_sys_i;

	isfl_link_if isfl_link_if_inst();
	isfl_dev isfl_dev_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link(isfl_link_if_inst.dev_mp),
		.cfg_serial_i(cfg), .bitmode_i(bm), .bitmode_wr_i(bm_wr), .tx_data_i(d_txd), .tx_valid_i(d_txv),
		.tx_ready_o(d_trdy), .rx_data_o(d_rxd), .rx_valid_o(d_rxv), .rx_ready_i(d_rdy), .pins_serial_o(pins),
		.link_held_o(held));
	isfl_ext #(.HALF_CYC(LINK_HALF_CYC)) isfl_ext_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.link(isfl_link_if_inst.ext_mp), .tx_data_i(e_txd), .tx_target_channel_bit_i(e_dst), .tx_valid_i(e_txv),
		.tx_ready_o(e_trdy), .rx_data_o(e_rxd), .rx_src_o(e_src), .rx_valid_o(e_rxv), .rx_ready_i(e_rdy));
	isfl_link_sva #(.HALF_CYC(LINK_HALF_CYC)) isfl_link_sva_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.link_clock_in(isfl_link_if_inst.link_clock_in), .serial_data_in(isfl_link_if_inst.serial_data_in),
		.serial_data_out(isfl_link_if_inst.serial_data_out),
		.clear_to_send_out(isfl_link_if_inst.clear_to_send_out));

	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic wait_rdy(input bit ext, input int ch);
		int i;
		for (i = 0; i < LIM; i++)
		begin
			@(posedge clk_sys_i);
			if ((ext ? e_trdy : d_trdy[ch]) === 1'b1)
				break;
		end
		if (i == LIM)
		begin
			failures++;
			$display("[ERR] %0t wait limit reached", $time);
			report_and_stop();
		end
	endtask

	task automatic dev_send(input int ch, input logic [7:0] d);
		exp_e[ch].push_back(d);
		@(negedge clk_sys_i);
		d_txd[ch] = d;
		d_txv[ch] = 1'b1;
		wait_rdy(1'b0, ch);
		@(negedge clk_sys_i);
		d_txv[ch] = 1'b0;
	endtask

	task automatic ext_send(input logic dst, input logic [7:0] d);
		exp_d.push_back({(dst | ~cfg[0]) ? 2'b10 : 2'b01, d});
		@(negedge clk_sys_i);
		e_txd = d;
		e_dst = dst;
		e_txv = 1'b1;
		wait_rdy(1'b1, 0);
		@(negedge clk_sys_i);
		e_txv = 1'b0;
	endtask

	task automatic drain();
		int i;
		for (i = 0; i < LIM && exp_e[0].size() + exp_e[1].size() + exp_d.size() > 0; i++)
			@(negedge clk_sys_i);
		chk(10'(i / LIM), 10'h000);
		if (i == LIM)
			report_and_stop();
	endtask

	task automatic do_reset(input logic [1:0] c);
		@(negedge clk_sys_i);
		sys_rst_i = 1'b1;
		cfg = c;
		repeat (10) @(negedge clk_sys_i);
		sys_rst_i = 1'b0;
		repeat (3) @(negedge clk_sys_i);
		chk({7'h00, pins, d_trdy}, {7'h00, |c, c});
		// Straps moved at run time must not change the mode
		cfg = ~c;
		repeat (3) @(negedge clk_sys_i);
		chk({7'h00, pins, d_trdy}, {7'h00, |c, c});
		cfg = c;
	endtask

	task automatic set_mode(input logic [7:0] v);
		@(negedge clk_sys_i);
		bm = v;
		bm_wr = 1'b1;
		@(negedge clk_sys_i);
		bm_wr = 1'b0;
		repeat (3) @(negedge clk_sys_i);
	endtask

	// Result watcher: each delivered byte against the oldest note
	always @(posedge clk_sys_i)
	begin
		if ((e_rxv & e_rdy) === 1'b1)
			chk({2'b00, exp_e[e_src].size() ? exp_e[e_src].pop_front() : ~e_rxd}, {2'b00, e_rxd});
		if ((|(d_rxv & d_rdy)) === 1'b1)
			chk(exp_d.size() ? exp_d.pop_front() : ~{d_rxv, d_rxd}, {d_rxv, d_rxd});
	end

	initial
	begin
		int k;
		do_reset(2'b11);
		// Full duplex, both channels and both targets
		for (k = 0; k < 4; k++)
			fork
				dev_send(0, 8'($random(seed)));
				dev_send(1, 8'($random(seed)));
				ext_send(k[0], 8'($random(seed)));
			join
		drain();
		@(negedge clk_sys_i);
		e_rdy = 1'b0;
		dev_send(0, 8'hFF);
		// Let the first byte land before the second is queued, so the order is fixed
		repeat (200) @(negedge clk_sys_i);
		dev_send(1, 8'h00);
		repeat (300) @(negedge clk_sys_i);
		chk({e_rxv, isfl_link_if_inst.link_clock_in, e_rxd}, {2'b10, 8'hFF});
		repeat (8)
		begin
			@(negedge clk_sys_i);
			chk({9'h000, isfl_link_if_inst.link_clock_in}, 10'h000);
		end
		e_rdy = 1'b1;
		drain();
		@(negedge clk_sys_i);
		d_rdy = 2'b00;
		ext_send(1'b1, 8'h5A);
		ext_send(1'b0, 8'hA5);
		repeat (300) @(negedge clk_sys_i);
		chk({1'b0, isfl_link_if_inst.clear_to_send_out, d_rxd}, {2'b00, 8'h5A});
		d_rdy = 2'b11;
		drain();
		set_mode(BITMODE_HOLD);
		dev_send(1, 8'($random(seed)));
		repeat (300) @(negedge clk_sys_i);
		chk({held, isfl_link_if_inst.serial_data_out, isfl_link_if_inst.clear_to_send_out, 7'(exp_e[1].size())},
			{3'b110, 7'h01});
		set_mode(BITMODE_RUN);
		drain();
		do_reset(2'b10);
		ext_send(1'b0, 8'($random(seed)));
		ext_send(1'b1, 8'($random(seed)));
		dev_send(1, 8'($random(seed)));
		drain();
		do_reset(2'b00);
		chk({9'h000, isfl_link_if_inst.clear_to_send_out}, 10'h000);
		report_and_stop();
	end
endmodule

// >>> hdl/isfl_dev.sv
// Function
// - Serial mode on either channel moves second-channel pins
// - Mode chosen only by configuration memory bits
// - Bit-mode 10 holds link; 0 releases
// - External device alone drives the link clock
// - Ready byte starts frame with low output
// - No outgoing start while receiving a frame
// - Outgoing start bit is always zero
// - Outgoing data bits leave least significant first
// - Last outgoing bit names origin channel
// - External device halts clock to refuse byte
// - External device starts only while clear-to-send high
// - Clear-to-send drops next rising edge after start
// - Incoming frames begin with zero start bit
// - Incoming data bits arrive least significant first
// - Route received byte by target channel bit
// - Clear-to-send low until room for byte
`timescale 1ns/1ns
module isfl_dev
	import isfl_pkg::*;
(
	// System
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	// Link
	isfl_link_if.dev_mp link,
	// Configuration memory and bit-mode command
	input wire logic [isfl_pkg::CH_NUM-1:0] cfg_serial_i,
	input wire logic [7:0] bitmode_i,
	input wire logic bitmode_wr_i,
	// Outgoing bytes, one port per channel
	input wire logic [isfl_pkg::CH_NUM-1:0][isfl_pkg::DATA_BITS-1:0] tx_data_i,
	input wire logic [isfl_pkg::CH_NUM-1:0] tx_valid_i,
	output logic [isfl_pkg::CH_NUM-1:0] tx_ready_o,
	// Incoming bytes
	output logic [isfl_pkg::DATA_BITS-1:0] rx_data_o,
	output logic [isfl_pkg::CH_NUM-1:0] rx_valid_o,
	input wire logic [isfl_pkg::CH_NUM-1:0] rx_ready_i,
	// Status
	output logic pins_serial_o,
	output logic link_held_o
);
	import isfl_pkg::*;

	logic [CH_NUM-1:0] cfg_mode;
	logic active;
	logic [2:0] clk_sync;
	logic [1:0] sdi_sync;
	logic rise;
	logic sdi_s;
	logic [CH_NUM-1:0][DATA_BITS-1:0] tx_buf;
	logic [CH_NUM-1:0] pending;
	logic [CH_NUM-1:0] next_pending;
	logic [CH_NUM-1:0] take;
	logic sel;
	logic last_src;
	logic tx_go;
	isfl_shift_state_t tx_state;
	logic [DATA_BITS:0] tx_shift;
	logic [3:0] tx_cnt;
	isfl_rx_state_t rx_state;
	logic [DATA_BITS:0] rx_shift;
	logic [3:0] rx_cnt;
	logic rx_done;
	logic rx_dst;
	logic room;

	// Mode bits are caught only while reset is applied
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			cfg_mode <= cfg_serial_i;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			pins_serial_o <= 1'b0;
		else
			pins_serial_o <= |cfg_mode;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			link_held_o <= 1'b0;
		else if (bitmode_wr_i && bitmode_i == BITMODE_HOLD)
			link_held_o <= 1'b1;
		else if (bitmode_wr_i && bitmode_i == BITMODE_RUN)
			link_held_o <= 1'b0;
	end

	assign active = pins_serial_o && !link_held_o;

	// Link clock and data input come from another domain
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			clk_sync <= 3'h0;
			sdi_sync <= 2'h3;
		end
		else
		begin
			clk_sync <= {clk_sync[1:0], link.link_clock_in};
			sdi_sync <= {sdi_sync[0], link.serial_data_in};
		end
	end

	assign rise = clk_sync[1] && !clk_sync[2];
	assign sdi_s = sdi_sync[1];

	// Outgoing byte holders; data is accepted even while the link is held
	generate
		for (genvar g = 0; g < CH_NUM; g++)
		begin : g_txbuf
			always_comb
			begin
				next_pending[g] = pending[g];
				if (take[g])
					next_pending[g] = 1'b0;
				else if (tx_valid_i[g] && tx_ready_o[g])
					next_pending[g] = 1'b1;
			end

			always_ff @(posedge clk_sys_i)
			begin
				if (sys_rst_i)
				begin
					pending[g] <= 1'b0;
					tx_ready_o[g] <= 1'b0;
				end
				else
				begin
					pending[g] <= next_pending[g];
					tx_ready_o[g] <= cfg_mode[g] && !next_pending[g];
					if (tx_valid_i[g] && tx_ready_o[g])
						tx_buf[g] <= tx_data_i[g];
				end
			end

			assign take[g] = tx_go && (sel == 1'(g));
		end
	endgenerate

	// Alternate between channels when both hold a byte
	assign sel = (pending[0] && (!pending[1] || last_src)) ? CH_FIRST : CH_SECOND;
	assign tx_go = active && rise && tx_state == SH_IDLE && (|pending)
		&& rx_state == RX_IDLE && sdi_s == IDLE_LVL;

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i || !active)
		begin
			tx_state <= SH_IDLE;
			link.serial_data_out <= IDLE_LVL;
			tx_shift <= '0;
			tx_cnt <= CNT_ZERO;
		end
		else if (rise)
		begin
			case (tx_state)
				SH_IDLE:
				begin
					if (tx_go)
					begin
						link.serial_data_out <= START_LVL;
						tx_shift <= {sel, tx_buf[sel]};
						tx_cnt <= BITS_AFTER_START;
						tx_state <= SH_BUSY;
					end
				end
				SH_BUSY:
				begin
					if (tx_cnt != CNT_ZERO)
					begin
						link.serial_data_out <= tx_shift[0];
						tx_shift <= {1'b0, tx_shift[DATA_BITS:1]};
						tx_cnt <= tx_cnt - LAST_BIT_CNT;
					end
					else
					begin
						link.serial_data_out <= IDLE_LVL;
						tx_state <= SH_IDLE;
					end
				end
				default:
				begin
					tx_state <= SH_IDLE;
					link.serial_data_out <= IDLE_LVL;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			last_src <= CH_SECOND;
		else if (tx_go)
			last_src <= sel;
	end

	assign room = !(|rx_valid_o);

	// Incoming frames; clear-to-send is lowered at a link edge, or at once when the link is held
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i || !active)
		begin
			rx_state <= RX_IDLE;
			link.clear_to_send_out <= 1'b0;
			rx_shift <= '0;
			rx_cnt <= CNT_ZERO;
		end
		else
		begin
			case (rx_state)
				RX_IDLE:
				begin
					link.clear_to_send_out <= room;
					if (rise && sdi_s == START_LVL && link.clear_to_send_out)
						rx_state <= RX_START;
				end
				RX_START:
				begin
					if (rise)
					begin
						link.clear_to_send_out <= 1'b0;
						rx_shift <= {sdi_s, rx_shift[DATA_BITS:1]};
						rx_cnt <= BITS_AFTER_D0;
						rx_state <= RX_DATA;
					end
				end
				RX_DATA:
				begin
					link.clear_to_send_out <= 1'b0;
					if (rise)
					begin
						rx_shift <= {sdi_s, rx_shift[DATA_BITS:1]};
						if (rx_cnt == LAST_BIT_CNT)
							rx_state <= RX_IDLE;
						else
							rx_cnt <= rx_cnt - LAST_BIT_CNT;
					end
				end
				default:
				begin
					rx_state <= RX_IDLE;
					link.clear_to_send_out <= 1'b0;
				end
			endcase
		end
	end

	assign rx_done = active && rise && rx_state == RX_DATA && rx_cnt == LAST_BIT_CNT;
	// A zero target falls back to the second channel when the first is not serial
	assign rx_dst = sdi_s | !cfg_mode[0];

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			rx_valid_o <= '0;
			rx_data_o <= '0;
		end
		else
		begin
			rx_valid_o <= rx_valid_o & ~rx_ready_i;
			if (rx_done)
			begin
				rx_data_o <= rx_shift[DATA_BITS:1];
				rx_valid_o[rx_dst] <= 1'b1;
			end
		end
	end
endmodule

// >>> hdl/isfl_ext.sv
`timescale 1ns/1ns
module isfl_ext
	import isfl_pkg::*;
#(
	parameter int HALF_CYC = isfl_pkg::LINK_HALF_CYC
)
(
	// System
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	// Link
	isfl_link_if.ext_mp link,
	// Bytes to send into the device
	input wire logic [isfl_pkg::DATA_BITS-1:0] tx_data_i,
	input wire logic tx_target_channel_bit_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	// Bytes received from the device
	output logic [isfl_pkg::DATA_BITS-1:0] rx_data_o,
	output logic rx_src_o,
	output logic rx_valid_o,
	input wire logic rx_ready_i
);
	import isfl_pkg::*;

	localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

	logic [7:0] div_cnt;
	logic [1:0] sdo_sync;
	logic [1:0] cts_sync;
	logic edge_due;
	logic stall;
	logic rise_ev;
	logic fall_ev;
	logic cts_seen;
	logic pending;
	logic next_pending;
	logic tx_go;
	logic [DATA_BITS:0] tx_buf;
	logic [DATA_BITS:0] tx_shift;
	logic [3:0] tx_cnt;
	isfl_shift_state_t tx_state;
	logic [DATA_BITS:0] rx_shift;
	logic [3:0] rx_cnt;
	isfl_shift_state_t rx_state;

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			sdo_sync <= 2'h3;
			cts_sync <= 2'h0;
		end
		else
		begin
			sdo_sync <= {sdo_sync[0], link.serial_data_out};
			cts_sync <= {cts_sync[0], link.clear_to_send_out};
		end
	end

	// Clock is held low when a start bit arrives and no byte can be taken
	assign stall = rx_state == SH_IDLE && sdo_sync[1] == START_LVL && rx_valid_o;
	assign edge_due = div_cnt == HALF_LAST;
	assign rise_ev = edge_due && !link.link_clock_in && !stall;
	assign fall_ev = edge_due && link.link_clock_in;

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			div_cnt <= 8'h00;
			link.link_clock_in <= 1'b0;
		end
		else if (edge_due)
		begin
			div_cnt <= 8'h00;
			if (rise_ev || fall_ev)
				link.link_clock_in <= !link.link_clock_in;
		end
		else
			div_cnt <= div_cnt + 8'h01;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			cts_seen <= 1'b0;
		else if (rise_ev)
			cts_seen <= cts_sync[1];
	end

	always_comb
	begin
		next_pending = pending;
		if (tx_go)
			next_pending = 1'b0;
		else if (tx_valid_i && tx_ready_o)
			next_pending = 1'b1;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			pending <= 1'b0;
			tx_ready_o <= 1'b0;
			tx_buf <= '0;
		end
		else
		begin
			pending <= next_pending;
			tx_ready_o <= !next_pending;
			if (tx_valid_i && tx_ready_o)
				tx_buf <= {tx_target_channel_bit_i, tx_data_i};
		end
	end

	// Data changes on the falling edge so it is stable at the next rise
	assign tx_go = fall_ev && tx_state == SH_IDLE && pending && cts_seen;

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			tx_state <= SH_IDLE;
			link.serial_data_in <= IDLE_LVL;
			tx_shift <= '0;
			tx_cnt <= CNT_ZERO;
		end
		else if (fall_ev)
		begin
			case (tx_state)
				SH_IDLE:
				begin
					if (tx_go)
					begin
						link.serial_data_in <= START_LVL;
						tx_shift <= tx_buf;
						tx_cnt <= BITS_AFTER_START;
						tx_state <= SH_BUSY;
					end
				end
				SH_BUSY:
				begin
					if (tx_cnt != CNT_ZERO)
					begin
						link.serial_data_in <= tx_shift[0];
						tx_shift <= {1'b0, tx_shift[DATA_BITS:1]};
						tx_cnt <= tx_cnt - LAST_BIT_CNT;
					end
					else
					begin
						link.serial_data_in <= IDLE_LVL;
						tx_state <= SH_IDLE;
					end
				end
				default:
				begin
					tx_state <= SH_IDLE;
					link.serial_data_in <= IDLE_LVL;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			rx_state <= SH_IDLE;
			rx_shift <= '0;
			rx_cnt <= CNT_ZERO;
			rx_data_o <= '0;
			rx_src_o <= CH_FIRST;
			rx_valid_o <= 1'b0;
		end
		else
		begin
			if (rx_ready_i)
				rx_valid_o <= 1'b0;
			if (rise_ev)
			begin
				case (rx_state)
					SH_IDLE:
					begin
						if (sdo_sync[1] == START_LVL)
						begin
							rx_cnt <= BITS_AFTER_START;
							rx_state <= SH_BUSY;
						end
					end
					SH_BUSY:
					begin
						rx_shift <= {sdo_sync[1], rx_shift[DATA_BITS:1]};
						if (rx_cnt == LAST_BIT_CNT)
						begin
							rx_data_o <= rx_shift[DATA_BITS:1];
							rx_src_o <= sdo_sync[1];
							rx_valid_o <= 1'b1;
							rx_state <= SH_IDLE;
						end
						else
							rx_cnt <= rx_cnt - LAST_BIT_CNT;
					end
					default:
						rx_state <= SH_IDLE;
				endcase
			end
		end
	end
endmodule

// >>> include/isfl_link_if.sv
`timescale 1ns/1ns
interface isfl_link_if;
	logic link_clock_in;
	logic serial_data_in;
	logic serial_data_out;
	logic clear_to_send_out;

	modport dev_mp (
		input link_clock_in,
		input serial_data_in,
		output serial_data_out,
		output clear_to_send_out
	);

	modport ext_mp (
		output link_clock_in,
		output serial_data_in,
		input serial_data_out,
		input clear_to_send_out
	);
endinterface

// >>> include/isfl_pkg.sv
package isfl_pkg;
	// Channel and byte geometry
	localparam int CH_NUM = 2;
	localparam int DATA_BITS = 8;
	localparam logic [3:0] FRAME_BITS = 4'hA;
	localparam logic [3:0] BITS_AFTER_START = 4'h9;
	localparam logic [3:0] BITS_AFTER_D0 = 4'h8;
	localparam logic [3:0] LAST_BIT_CNT = 4'h1;
	localparam logic [3:0] CNT_ZERO = 4'h0;

	// Line levels and channel codes
	localparam logic START_LVL = 1'b0;
	localparam logic IDLE_LVL = 1'b1;
	localparam logic CH_FIRST = 1'b0;
	localparam logic CH_SECOND = 1'b1;

	// Bit-mode command values
	localparam logic [7:0] BITMODE_HOLD = 8'h10;
	localparam logic [7:0] BITMODE_RUN = 8'h00;

	// Link clock made by the external end
	localparam int SYS_PERIOD_NS = 20;
	localparam int LINK_PERIOD_NS = 160;
	localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);

	typedef enum logic [1:0] {
		SH_IDLE = 2'b01,
		SH_BUSY = 2'b10
	} isfl_shift_state_t;

	typedef enum logic [2:0] {
		RX_IDLE = 3'b001,
		RX_START = 3'b010,
		RX_DATA = 3'b100
	} isfl_rx_state_t;
endpackage
